// ---- chain_frame_pkg.sv ----
// package: constants and types shared by the daisy-chain packet framer
package chain_frame_pkg;
  localparam int          CLK_MHZ       = 125;
  localparam int          BIT_NS        = 500;
  localparam int          BIT_CYC       = (BIT_NS * CLK_MHZ) / 1000;
  localparam logic [6:0]  BIT_LAST      = 7'(BIT_CYC - 1);
  localparam logic [3:0]  CHAR_LAST     = 4'hb;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          CHAR_W        = 6;
  localparam logic [2:0]  RDY_LEVEL     = 3'h1;
  localparam logic [7:0]  PRE_CODE      = 8'h15;
  localparam logic [7:0]  STOP_CODE     = 8'h54;
  localparam logic [7:0]  CMD_ENUM      = 8'h57;
  localparam logic [7:0]  CMD_ALERT     = 8'h21;
  localparam logic [7:0]  CMD_BWR       = 8'h02;
  localparam logic [7:0]  CMD_BRD       = 8'h03;
  localparam logic [7:0]  CMD_UP        = 8'h08;
  localparam logic [7:0]  CMD_DN        = 8'h09;
  localparam logic [2:0]  LOW_SWR       = 3'h4;
  localparam logic [2:0]  LOW_SRD       = 3'h5;
  localparam logic [2:0]  LOW_BLK       = 3'h6;
  localparam logic [7:0]  REG_IDX       = 8'h01;
  localparam logic [7:0]  BLK_REG_IDX   = 8'h02;
  localparam logic [7:0]  WR_LO_IDX     = 8'h02;
  localparam logic [7:0]  WR_HI_IDX     = 8'h03;
  localparam logic [7:0]  WR_PEC_IDX    = 8'h04;
  localparam logic [7:0]  HOST_PEC_IDX  = 8'h03;
  localparam logic [7:0]  ENUM_ADDR_IDX = 8'h02;
  localparam logic [7:0]  RD_FILL_IDX   = 8'h02;
  localparam logic [7:0]  BLK_FILL_IDX  = 8'h03;
  localparam logic [7:0]  SRD_FILL_LEN  = 8'h02;
  localparam logic [7:0]  NO_IDX        = 8'hff;
  localparam logic [5:0]  BLK_MAX       = 6'h20;
  localparam int          DC_PEC_BIT    = 7;
  localparam logic [7:0]  CRC_POLY      = 8'hb2;
  localparam logic [7:0]  CRC_SEED      = 8'h00;
  localparam logic [4:0]  NODE_RST      = 5'h00;
  localparam logic        HOST_UP_RST   = 1'b1;

  typedef enum logic [1:0] {KIND_DATA, KIND_PRE, KIND_STOP} char_kind_e;
  typedef enum logic [1:0] {SER_IDLE, SER_LEAD, SER_SHIFT} ser_state_e;
endpackage : chain_frame_pkg

// ---- char_fifo.sv ----
// character fifo between packet editor and line serializer
`timescale 1ns/1ps
module char_fifo #(
  parameter int W = 6,
  parameter int D = 4
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       in_valid_i,
  input  wire logic [W-1:0]               in_data_i,
  output logic                            in_ready_o,
  output logic                            out_valid_o,
  output logic [W-1:0]                    out_data_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(D+1)-1:0]          level_o
);
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [LW-1:0]       cnt;
  } fifo_s;

  fifo_s st_ff;
  fifo_s nxt_st;
  logic  push;
  logic  pop;

  assign in_ready_o  = st_ff.cnt != LW'(D);
  assign out_valid_o = st_ff.cnt != '0;
  assign out_data_o  = st_ff.mem[st_ff.rp];
  assign level_o     = st_ff.cnt;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = (st_ff.wp == AW'(D - 1)) ? '0 : st_ff.wp + AW'(1);
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(D - 1)) ? '0 : st_ff.rp + AW'(1);
    end
    nxt_st.cnt = st_ff.cnt + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : char_fifo

// ---- chain_framer.sv ----
// daisy-chain packet framer: edits passing packets and drives the line
`timescale 1ns/1ps
module chain_framer
  import chain_frame_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        rx_valid_i,
  input  wire chain_frame_pkg::char_kind_e rx_kind_i,
  input  wire logic [3:0]                  rx_nibble_i,
  input  wire logic                        rx_down_path_i,
  output logic                             rx_ready_o,
  input  wire logic                        idle_hiz_i,
  input  wire logic                        liveness_counter_enable_i,
  input  wire logic [4:0]                  last_address_i,
  input  wire logic [5:0]                  alert_status_i,
  input  wire logic [5:0]                  alert_mask_settings_i,
  input  wire logic                        crc_flag_clear_i,
  input  wire logic [15:0]                 reg_rd_data_i,
  input  wire logic                        reg_addr_valid_i,
  output logic [7:0]                       reg_addr_o,
  output logic                             reg_wr_o,
  output logic [15:0]                      reg_wr_data_o,
  output logic [4:0]                       node_address_o,
  output logic                             host_path_select_o,
  output logic                             crc_error_up_flag_o,
  output logic                             crc_error_down_flag_o,
  output logic                             crc_error_rollup_flag_o,
  output logic                             positive_tx_output_o,
  output logic                             negative_tx_output_o,
  output logic                             tx_drive_en_o
);
  import chain_frame_pkg::*;

  typedef struct packed {
    logic        in_pkt;
    logic        have_lo;
    logic [3:0]  lo;
    logic [7:0]  idx;
    logic [7:0]  cmd;
    logic        addressed;
    logic        modified;
    logic [7:0]  rx_crc;
    logic [7:0]  tx_crc;
    logic [4:0]  node;
    logic        host_up;
    logic [7:0]  reg_addr;
    logic [15:0] wr_data;
    logic        wr;
    logic        up_err;
    logic        dn_err;
    logic        roll_err;
    logic        pend;
    logic [5:0]  pend_char;
    logic        rdy;
    ser_state_e  ser;
    logic [11:0] sh;
    logic [3:0]  nbit;
    logic [6:0]  cyc;
    logic        tx_p;
    logic        tx_n;
    logic        tx_oe;
  } st_s;

  st_s         st_ff;
  st_s         nxt_st;
  logic        take;
  logic        byte_fire;
  logic        push_valid;
  logic [5:0]  push_data;
  logic        fifo_in_ready;
  logic        pop_valid;
  logic [5:0]  pop_data;
  logic        pop_ready;
  logic [2:0]  fifo_level;
  logic [7:0]  b;
  logic [7:0]  ob;
  logic        pec_err;
  logic        is_enum;
  logic        is_bwr;
  logic        is_brd;
  logic        is_swr;
  logic        is_srd;
  logic        is_blk;
  logic        is_host;
  logic        is_read;
  logic        is_write;
  logic        mine;
  logic [5:0]  blk_n;
  logic [7:0]  fill_start;
  logic [7:0]  fill_off;
  logic [7:0]  dc_idx;
  logic [7:0]  pec_idx;
  logic [7:0]  alive_idx;
  logic        in_fill;
  logic        fill_mine;
  logic [7:0]  my_dc;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // bit 0 leaves the line first
  function automatic logic [11:0] char_bits(input logic [5:0] ch);
    logic [11:0] r;
    logic [3:0]  n;
    n = ch[3:0];
    case (char_kind_e'(ch[5:4]))
      KIND_PRE:  r = {3'b111, PRE_CODE, 1'b0};
      KIND_STOP: r = {3'b111, STOP_CODE, 1'b0};
      default:   r = {3'b110, ~n[3], n[3], ~n[2], n[2], ~n[1], n[1], ~n[0], n[0], 1'b0};
    endcase
    return r;
  endfunction : char_bits

  // command decode
  assign is_enum  = st_ff.cmd == CMD_ENUM;
  assign is_bwr   = st_ff.cmd == CMD_BWR;
  assign is_brd   = st_ff.cmd == CMD_BRD;
  assign is_swr   = st_ff.cmd[2:0] == LOW_SWR;
  assign is_srd   = st_ff.cmd[2:0] == LOW_SRD;
  assign is_blk   = st_ff.cmd[2:0] == LOW_BLK;
  assign is_host  = (st_ff.cmd == CMD_UP) || (st_ff.cmd == CMD_DN);
  assign is_read  = is_brd || is_srd || is_blk;
  assign is_write = is_bwr || is_swr;
  assign mine     = is_bwr || is_brd || st_ff.addressed;
  // a zero count field stands for the largest block
  assign blk_n    = (st_ff.cmd[7:3] == 5'h00) ? BLK_MAX : {1'b0, st_ff.cmd[7:3]};

  // packet layout from the command
  assign fill_start = is_blk ? BLK_FILL_IDX : RD_FILL_IDX;
  assign dc_idx     = is_brd ? RD_FILL_IDX + {1'b0, {1'b0, last_address_i} + 6'h01, 1'b0} :
                      is_srd ? RD_FILL_IDX + SRD_FILL_LEN :
                               BLK_FILL_IDX + {1'b0, blk_n, 1'b0};
  assign pec_idx    = is_read  ? dc_idx + 8'h01 :
                      is_write ? WR_PEC_IDX :
                      is_host  ? HOST_PEC_IDX : NO_IDX;
  assign alive_idx  = pec_idx + 8'h01;
  assign fill_off   = st_ff.idx - fill_start;
  assign in_fill    = is_read && (st_ff.idx >= fill_start) && (st_ff.idx < dc_idx);
  assign fill_mine  = is_brd ? (fill_off[7:1] == {2'b00, st_ff.node}) : st_ff.addressed;
  // only alerts whose mask bit is set get in; crc error of the issuing path in bit 7
  assign my_dc      = {rx_down_path_i ? st_ff.dn_err : st_ff.up_err,
                       alert_status_i & alert_mask_settings_i, 1'b0};

  assign take      = rx_valid_i && st_ff.rdy;
  assign byte_fire = take && (rx_kind_i == KIND_DATA) && st_ff.in_pkt && st_ff.have_lo;
  assign pop_ready = (st_ff.ser == SER_IDLE) ||
                     ((st_ff.ser == SER_SHIFT) && (st_ff.nbit == CHAR_LAST) &&
                      (st_ff.cyc == BIT_LAST));

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.wr  = 1'b0;
    push_valid = 1'b0;
    push_data  = '0;
    b          = {rx_nibble_i, st_ff.lo};
    ob         = b;
    pec_err    = 1'b0;
    if (crc_flag_clear_i) begin
      nxt_st.up_err   = 1'b0;
      nxt_st.dn_err   = 1'b0;
      nxt_st.roll_err = 1'b0;
    end
    if (st_ff.pend) begin
      push_valid  = 1'b1;
      push_data   = st_ff.pend_char;
      nxt_st.pend = 1'b0;
    end
    if (take) begin
      case (rx_kind_i)
        KIND_PRE: begin
          nxt_st.in_pkt    = 1'b1;
          nxt_st.have_lo   = 1'b0;
          nxt_st.idx       = '0;
          nxt_st.cmd       = '0;
          nxt_st.addressed = 1'b0;
          nxt_st.modified  = 1'b0;
          nxt_st.rx_crc    = CRC_SEED;
          nxt_st.tx_crc    = CRC_SEED;
          push_valid       = 1'b1;
          push_data        = {KIND_PRE, 4'h0};
        end
        KIND_STOP: begin
          // a lone trailing nibble is passed on ahead of the stop
          nxt_st.in_pkt  = 1'b0;
          nxt_st.have_lo = 1'b0;
          push_valid     = 1'b1;
          if (st_ff.have_lo) begin
            push_data        = {KIND_DATA, st_ff.lo};
            nxt_st.pend      = 1'b1;
            nxt_st.pend_char = {KIND_STOP, 4'h0};
          end else begin
            push_data = {KIND_STOP, 4'h0};
          end
        end
        default: begin
          if (!st_ff.in_pkt) begin
            push_valid = 1'b1;
            push_data  = {KIND_DATA, rx_nibble_i};
          end else if (!st_ff.have_lo) begin
            nxt_st.have_lo = 1'b1;
            nxt_st.lo      = rx_nibble_i;
          end else begin
            nxt_st.have_lo = 1'b0;
            if (st_ff.idx == 8'h00) begin
              nxt_st.cmd       = b;
              nxt_st.addressed = ((b[2:0] == LOW_SWR) || (b[2:0] == LOW_SRD)) &&
                                 (b[7:3] == st_ff.node);
            end
            if (is_blk && st_ff.idx == REG_IDX) begin
              nxt_st.addressed = b[4:0] == st_ff.node;
            end
            if ((!is_blk && st_ff.idx == REG_IDX) || (is_blk && st_ff.idx == BLK_REG_IDX)) begin
              nxt_st.reg_addr = b;
            end
            if (is_enum && st_ff.idx == ENUM_ADDR_IDX && !rx_down_path_i) begin
              nxt_st.node = b[4:0];
              ob          = b + 8'h01;
            end
            if (is_write && st_ff.idx == WR_LO_IDX) begin
              nxt_st.wr_data[7:0] = b;
            end
            if (is_write && st_ff.idx == WR_HI_IDX) begin
              nxt_st.wr_data[15:8] = b;
            end
            // register data replaces only this node's fill slots
            if (in_fill && fill_mine && reg_addr_valid_i) begin
              ob              = fill_off[0] ? reg_rd_data_i[15:8] : reg_rd_data_i[7:0];
              nxt_st.modified = 1'b1;
              if (fill_off[0] && is_blk) begin
                nxt_st.reg_addr = st_ff.reg_addr + 8'h01;
              end
            end
            if (is_read && mine && st_ff.idx == dc_idx) begin
              ob              = b | my_dc;
              nxt_st.modified = st_ff.modified || (ob != b);
            end
            if (st_ff.idx == pec_idx) begin
              pec_err = b != st_ff.rx_crc;
              if (pec_err) begin
                nxt_st.up_err   = nxt_st.up_err || !rx_down_path_i;
                nxt_st.dn_err   = nxt_st.dn_err || rx_down_path_i;
                nxt_st.roll_err = 1'b1;
              end
              // an edited packet carries a fresh crc; an untouched one keeps the old
              if (st_ff.modified) begin
                ob = st_ff.tx_crc;
              end
              // writes land only with good crc and a valid address
              nxt_st.wr = !pec_err && is_write && mine && reg_addr_valid_i;
              if (!pec_err && is_host) begin
                nxt_st.host_up = st_ff.cmd == CMD_UP;
              end
            end
            if (liveness_counter_enable_i && (is_read || is_write) && mine &&
                st_ff.idx == alive_idx) begin
              ob = b + 8'h01;
            end
            if (st_ff.idx < pec_idx) begin
              nxt_st.rx_crc = crc_step(st_ff.rx_crc, b);
              nxt_st.tx_crc = crc_step(st_ff.tx_crc, ob);
            end
            if (st_ff.idx != NO_IDX) begin
              nxt_st.idx = st_ff.idx + 8'h01;
            end
            // low nibble first, high nibble one cycle later
            push_valid       = 1'b1;
            push_data        = {KIND_DATA, ob[3:0]};
            nxt_st.pend      = 1'b1;
            nxt_st.pend_char = {KIND_DATA, ob[7:4]};
          end
        end
      endcase
    end
    // leaves headroom for the split byte so a push never meets a full fifo
    nxt_st.rdy = !nxt_st.pend && (fifo_level <= RDY_LEVEL);

    // line serializer
    case (st_ff.ser)
      SER_IDLE: begin
        if (pop_valid) begin
          nxt_st.ser = SER_LEAD;
          nxt_st.sh  = char_bits(pop_data);
          nxt_st.cyc = '0;
        end
      end
      SER_LEAD: begin
        nxt_st.cyc = st_ff.cyc + 7'h01;
        if (st_ff.cyc == BIT_LAST) begin
          nxt_st.ser  = SER_SHIFT;
          nxt_st.cyc  = '0;
          nxt_st.nbit = '0;
        end
      end
      SER_SHIFT: begin
        nxt_st.cyc = st_ff.cyc + 7'h01;
        if (st_ff.cyc == BIT_LAST) begin
          nxt_st.cyc  = '0;
          nxt_st.nbit = st_ff.nbit + 4'h1;
          if (st_ff.nbit == CHAR_LAST) begin
            // back-to-back characters skip idle; otherwise drop to idle at once
            nxt_st.nbit = '0;
            nxt_st.sh   = char_bits(pop_data);
            nxt_st.ser  = pop_valid ? SER_SHIFT : SER_IDLE;
          end
        end
      end
      default: nxt_st.ser = SER_IDLE;
    endcase
    case (nxt_st.ser)
      SER_LEAD: begin
        nxt_st.tx_p  = 1'b1;
        nxt_st.tx_n  = 1'b0;
        nxt_st.tx_oe = 1'b1;
      end
      SER_SHIFT: begin
        nxt_st.tx_p  = nxt_st.sh[nxt_st.nbit];
        nxt_st.tx_n  = !nxt_st.sh[nxt_st.nbit];
        nxt_st.tx_oe = 1'b1;
      end
      default: begin
        nxt_st.tx_p  = 1'b0;
        nxt_st.tx_n  = 1'b0;
        nxt_st.tx_oe = !idle_hiz_i;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_ff         <= '0;
      st_ff.ser     <= SER_IDLE;
      st_ff.node    <= NODE_RST;
      st_ff.host_up <= HOST_UP_RST;
      st_ff.tx_oe   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  char_fifo #(
    .W (CHAR_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_valid),
    .in_data_i   (push_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (pop_valid),
    .out_data_o  (pop_data),
    .out_ready_i (pop_ready),
    .level_o     (fifo_level)
  );

  assign rx_ready_o              = st_ff.rdy;
  assign reg_addr_o              = st_ff.reg_addr;
  assign reg_wr_o                = st_ff.wr;
  assign reg_wr_data_o           = st_ff.wr_data;
  assign node_address_o          = st_ff.node;
  assign host_path_select_o      = st_ff.host_up;
  assign crc_error_up_flag_o     = st_ff.up_err;
  assign crc_error_down_flag_o   = st_ff.dn_err;
  assign crc_error_rollup_flag_o = st_ff.roll_err;
  assign positive_tx_output_o    = st_ff.tx_p;
  assign negative_tx_output_o    = st_ff.tx_n;
  assign tx_drive_en_o           = st_ff.tx_oe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  stop_char_a: assert property (
    pop_valid && pop_ready && pop_data[5:4] == KIND_STOP |=> st_ff.sh == 12'hea8)
    else $error("stop character pattern wrong");
  pre_char_a: assert property (
    pop_valid && pop_ready && pop_data[5:4] == KIND_PRE |=> st_ff.sh == 12'he2a)
    else $error("start character pattern wrong");
  data_char_a: assert property (
    pop_valid && pop_ready && pop_data[5:4] == KIND_DATA |=>
    st_ff.sh[0] == 1'b0 && st_ff.sh[11:9] == 3'b110 &&
    st_ff.sh[8:1] == (($past(pop_data[3], 1) ? 8'b01 : 8'b10) << 6 |
    ($past(pop_data[2], 1) ? 8'b01 : 8'b10) << 4 |
    ($past(pop_data[1], 1) ? 8'b01 : 8'b10) << 2 | ($past(pop_data[0], 1) ? 8'b01 : 8'b10)))
    else $error("data character encoding wrong");
  idle_level_a: assert property (
    st_ff.ser == SER_IDLE |-> !positive_tx_output_o && !negative_tx_output_o &&
    tx_drive_en_o == !$past(idle_hiz_i))
    else $error("idle outputs wrong");
  lead_high_a: assert property (
    st_ff.ser == SER_IDLE ##1 st_ff.ser == SER_LEAD |->
    positive_tx_output_o && tx_drive_en_o ##62 st_ff.ser == SER_SHIFT && !positive_tx_output_o)
    else $error("lead-in before start bit wrong");
  addr_filter_a: assert property (
    reg_wr_o |-> st_ff.cmd == CMD_BWR || (st_ff.addressed && st_ff.cmd[7:3] == st_ff.node))
    else $error("write for another node taken");
  host_up_a: assert property (
    byte_fire && st_ff.idx == pec_idx && !pec_err && st_ff.cmd == CMD_UP |=> host_path_select_o)
    else $error("up-path command did not set path select");
  host_dn_a: assert property (
    byte_fire && st_ff.idx == pec_idx && !pec_err && st_ff.cmd == CMD_DN |=> !host_path_select_o)
    else $error("down-path command did not clear path select");
  crc_flag_a: assert property (
    byte_fire && pec_err && !rx_down_path_i |=> crc_error_up_flag_o && crc_error_rollup_flag_o)
    else $error("crc error flags not set");
  dc_or_a: assert property (
    byte_fire && is_read && st_ff.idx == dc_idx |-> (ob & b) == b && (mine || ob == b))
    else $error("check/status byte not an OR");
  alive_inc_a: assert property (
    byte_fire && liveness_counter_enable_i && (is_bwr || is_brd) && st_ff.idx == alive_idx
    |-> ob == b + 8'h01)
    else $error("liveness counter not incremented");
  fifo_push_a: assert property (
    push_valid |-> fifo_in_ready)
    else $error("character dropped at fifo");

  stop_sent_c: cover property (pop_valid && pop_ready && pop_data[5:4] == KIND_STOP);
  crc_err_c: cover property (byte_fire && pec_err);
  fill_c: cover property (byte_fire && in_fill && fill_mine && reg_addr_valid_i);
  host_c: cover property (byte_fire && is_host && st_ff.idx == pec_idx);
endmodule : chain_framer

// ---- line_monitor.sv ----
// line receiver model standing at the far end of the link
`timescale 1ns/1ps
module line_monitor (
  input  wire logic clk_i,
  input  wire logic pos_i,
  input  wire logic neg_i
);
  import chain_frame_pkg::*;
  logic [11:0] chars[$];
  logic [11:0] c;
  // idle shows both lines low, so only pos low with neg high is a start bit
  initial begin
    forever begin
      @(posedge clk_i);
      if (!pos_i && neg_i) begin
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 12; i++) begin
          c[i] = pos_i; // bit 0 first
          if (i < 11) repeat (BIT_CYC) @(posedge clk_i);
        end
        chars.push_back(c);
      end
    end
  end
endmodule : line_monitor

// ---- test_chain_framer.sv ----
// self-checking bench for the daisy-chain packet framer
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_chain_framer;
  import chain_frame_pkg::*;
  logic       clk_i = 0, reset_n_i = 0, rx_valid_i = 0, rx_down_path_i = 0;
  logic       idle_hiz_i = 0, live_en = 0, addr_ok = 1;
  logic [5:0] alerts = 6'h05, amask = 6'h0c;
  logic [15:0] rd_data = 16'hbeef, wdata;
  logic [7:0] waddr;
  char_kind_e rx_kind_i = KIND_DATA;
  logic [3:0] rx_nibble_i = 4'h0;
  logic [4:0] node;
  logic       rdy, wr, host, pos, neg, oe, up_f, dn_f, roll_f;
  int         fails = 0, n_tests = 0, n_wr = 0;
  chain_framer chain_framer_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .rx_valid_i(rx_valid_i), .rx_kind_i(rx_kind_i), .rx_nibble_i(rx_nibble_i),
    .rx_down_path_i(rx_down_path_i), .rx_ready_o(rdy), .idle_hiz_i(idle_hiz_i),
    .liveness_counter_enable_i(live_en), .last_address_i(5'h00),
    .alert_status_i(alerts), .alert_mask_settings_i(amask), .crc_flag_clear_i(1'b0),
    .reg_rd_data_i(rd_data), .reg_addr_valid_i(addr_ok), .reg_addr_o(waddr), .reg_wr_o(wr),
    .reg_wr_data_o(wdata), .node_address_o(node), .host_path_select_o(host),
    .crc_error_up_flag_o(up_f), .crc_error_down_flag_o(dn_f), .crc_error_rollup_flag_o(roll_f),
    .positive_tx_output_o(pos), .negative_tx_output_o(neg), .tx_drive_en_o(oe));
  line_monitor line_monitor_inst (.clk_i(clk_i), .pos_i(pos), .neg_i(neg));
  always @(posedge clk_i) if (wr) n_wr <= n_wr + 1;
  initial forever #4 clk_i = ~clk_i;
  function automatic logic [11:0] enc(input char_kind_e k, input logic [7:0] v);
    logic [11:0] e;
    e = {2'b11, k != KIND_DATA, v, 1'b0};
    if (k == KIND_DATA)
      for (int i = 0; i < 4; i++) e[2*i+1 +: 2] = {~v[i], v[i]};
    return e;
  endfunction : enc
  // independent crc model built from the shared polynomial and seed
  function automatic logic [7:0] crc8(input logic [7:0] d[$]);
    logic [7:0] r;
    r = CRC_SEED;
    foreach (d[i]) begin
      r = r ^ d[i];
      for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
    end
    return r;
  endfunction : crc8
  task automatic put(input char_kind_e k, input logic [3:0] n);
    @(negedge clk_i);
    rx_valid_i = 1'b1;
    rx_kind_i = k;
    rx_nibble_i = n;
    for (int w = 0; w < 2000 && rdy !== 1'b1; w++) @(negedge clk_i);
    @(negedge clk_i);
    rx_valid_i = 1'b0;
  endtask : put
  task automatic xfer(input logic [7:0] tx[$], input logic [7:0] rx[$]);
    line_monitor_inst.chars.delete();
    put(KIND_PRE, 4'h0);
    foreach (tx[i]) begin
      put(KIND_DATA, tx[i][3:0]);
      put(KIND_DATA, tx[i][7:4]);
    end
    put(KIND_STOP, 4'h0);
    for (int w = 0; w < 20000 && line_monitor_inst.chars.size() < 2*rx.size()+2; w++)
      @(negedge clk_i);
    `CHK(line_monitor_inst.chars[0], enc(KIND_PRE, PRE_CODE))
    foreach (rx[i]) begin
      `CHK(line_monitor_inst.chars[2*i+1], enc(KIND_DATA, rx[i]))
      `CHK(line_monitor_inst.chars[2*i+2], enc(KIND_DATA, rx[i] >> 4))
    end
    `CHK(line_monitor_inst.chars[2*rx.size()+1], enc(KIND_STOP, STOP_CODE))
  endtask : xfer
  task automatic t_idle;
    `CHK({host, node, wr, pos, neg, oe}, {1'b1, 5'h00, 1'b0, 2'b00, 1'b1})
    @(negedge clk_i) idle_hiz_i = 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK(oe, 1'b0)
    idle_hiz_i = 1'b0;
    $display("idle test done");
  endtask : t_idle
  task automatic t_alert;
    int n = 0;
    fork
      xfer('{CMD_ALERT, 8'ha5}, '{CMD_ALERT, 8'ha5});
      begin
        while (pos !== 1'b1) @(negedge clk_i);
        while (pos === 1'b1) begin n++; @(negedge clk_i); end
        `CHK(n, BIT_CYC)
      end
    join
    $display("alert pass-through test done");
  endtask : t_alert
  task automatic t_enum;
    xfer('{CMD_ENUM, 8'h00, 8'h05}, '{CMD_ENUM, 8'h00, 8'h06});
    `CHK(node, 5'h05)
    rx_down_path_i = 1'b1;
    xfer('{CMD_ENUM, 8'h00, 8'h09}, '{CMD_ENUM, 8'h00, 8'h09});
    `CHK(node, 5'h05)
    rx_down_path_i = 1'b0;
    $display("enumeration test done");
  endtask : t_enum
  task automatic t_other_node;
    logic [7:0] q[$];
    // good crc, so only the address filter can keep node 5 from writing
    q = '{8'h1c, 8'h10, 8'h34, 8'h12};
    q.push_back(crc8(q));
    xfer(q, q);
    `CHK(n_wr, 0)
    `CHK(roll_f, 1'b0)
    $display("foreign address test done");
  endtask : t_other_node
  task automatic t_write;
    logic [7:0] q[$];
    logic [7:0] c;
    q = '{8'h2c, 8'h10, 8'h34, 8'h12};
    c = crc8(q);
    live_en = 1'b1;
    xfer('{8'h2c, 8'h10, 8'h34, 8'h12, c, 8'h07}, '{8'h2c, 8'h10, 8'h34, 8'h12, c, 8'h08});
    `CHK(n_wr, 1)
    `CHK({wdata, waddr}, {16'h1234, 8'h10})
    xfer('{8'h2c, 8'h10, 8'h34, 8'h12, ~c, 8'h07}, '{8'h2c, 8'h10, 8'h34, 8'h12, ~c, 8'h08});
    `CHK(n_wr, 1)
    `CHK({up_f, dn_f, roll_f}, 3'b101)
    $display("register write test done");
  endtask : t_write
  task automatic t_read;
    logic [7:0] q[$];
    logic [7:0] r[$];
    q = '{8'h2d, 8'h20, 8'hc2, 8'hd3, 8'h00};
    // fill slots take the register, status ors in the up-path crc flag and masked alerts
    r = '{8'h2d, 8'h20, 8'hef, 8'hbe, 8'h88};
    q.push_back(crc8(q));
    q.push_back(8'h30);
    r.push_back(crc8(r));
    r.push_back(8'h31);
    xfer(q, r);
    `CHK(waddr, 8'h20)
    $display("single read test done");
  endtask : t_read
  task automatic t_host;
    logic [7:0] q[$];
    q = '{CMD_DN, 8'h00, 8'h00};
    q.push_back(crc8(q));
    xfer(q, q);
    `CHK(host, 1'b0)
    q = '{CMD_UP, 8'h00, 8'h00};
    q.push_back(crc8(q));
    xfer(q, q);
    `CHK(host, 1'b1)
    $display("path select test done");
  endtask : t_host
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    #720000;
    fails++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    t_idle();
    t_alert();
    t_enum();
    t_other_node();
    t_write();
    t_read();
    t_host();
    final_report();
  end
endmodule : test_chain_framer
